// [tdst_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tdst_regs.svh"
module tdst_core (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // sample stream
   input wire logic smp_valid_in,
   input wire tdst_pkg::tdst_in_t smp_in,
   output logic smp_ready_out,
   // frame configuration
   input wire tdst_pkg::tdst_cfg_t cfg_in,
   input wire logic [7:0] hl_thr_in,
   input wire logic [7:0] io_thr_in,
   // window table
   output logic [9:0] win_addr_out,
   input wire logic [15:0] win_coef_in,
   // short spectra in
   input wire logic coef_valid_in,
   input wire logic [23:0] coef_in,
   output logic coef_ready_out,
   // output stream
   output wire logic out_valid_out,
   input wire logic out_ready_in,
   output wire tdst_pkg::tdst_out_t out_data_out,
   // decision
   output logic transient_flag_out,
   output logic flag_valid_out
);
   tdst_pkg::tdst_state_t state;
   tdst_pkg::tdst_cfg_t cfg;
   tdst_pkg::tdst_cfg_t cur;
   tdst_pkg::tdst_out_t push_data;
   logic [9:0] len, half, qtr, eighth, n;
   logic [7:0] kq;
   logic [1:0] m, drain;
   logic smp_take, frame_start, clr;

   function automatic logic [9:0] frame_len(input tdst_pkg::tdst_bw_t bw);
      case (bw)
         tdst_pkg::BW_NB: frame_len = `TDST_LEN_NB;
         tdst_pkg::BW_WB: frame_len = `TDST_LEN_WB;
         tdst_pkg::BW_SWB: frame_len = `TDST_LEN_SWB;
         default: frame_len = `TDST_LEN_FB;
      endcase
   endfunction

   function automatic logic [9:0] band_len(input tdst_pkg::tdst_bw_t bw, input logic [3:0] idx,
                                           input logic [9:0] start, input logic [9:0] q);
      logic [7:0] w;
      w = 8'h00;
      case (bw)
         tdst_pkg::BW_WB: w = (idx < 4'h5) ? `TDST_BAND_A : 8'h00;
         tdst_pkg::BW_SWB: w = (idx < 4'h4) ? `TDST_BAND_A : (idx < 4'h8) ? `TDST_BAND_B : 8'h00;
         tdst_pkg::BW_FB: begin
            w = (idx < 4'h4) ? `TDST_BAND_A : (idx < 4'h7) ? `TDST_BAND_B :
               (idx < 4'h9) ? `TDST_BAND_C : 8'h00;
         end
         default: w = 8'h00;
      endcase
      // remainder past the table is one last band
      band_len = (w == 8'h00) ? 10'(q - start) : {2'h0, w};
   endfunction

   assign cur = (state == tdst_pkg::ST_COLLECT && n == 10'h000) ? cfg_in : cfg;
   assign len = frame_len(cur.bw);
   assign half = {1'b0, len[9:1]};
   assign qtr = {2'h0, len[9:2]};
   assign eighth = {3'h0, len[9:3]};
   assign smp_take = smp_valid_in & smp_ready_out;
   assign frame_start = smp_take && n == 10'h000;
   assign clr = frame_start & cfg_in.layer_change;

   // high-pass filter, state kept across frames until a frame start with layer change clears it
   logic signed [17:0] y, y_base;
   logic signed [15:0] x1, x1_base;
   logic signed [16:0] dx;
   logic signed [35:0] hp_sum;
   assign y_base = clr ? 18'sh00000 : y;
   assign x1_base = clr ? 16'sh0000 : x1;
   assign dx = $signed({smp_in.hp[15], smp_in.hp}) - $signed({x1_base[15], x1_base});
   assign hp_sum = 36'(y_base * $signed({1'b0, `TDST_HP_POLE}))
      + 36'(dx * $signed({1'b0, `TDST_HP_ZERO}));

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         y <= 18'sh00000;
         x1 <= 16'sh0000;
      end else if (smp_take) begin
         y <= hp_sum[32:15];
         x1 <= smp_in.hp;
      end
   end

   // sample, sub-frame and frame counters
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         n <= 10'h000;
         kq <= 8'h00;
         m <= 2'h0;
         cfg <= '0;
      end else if (smp_take) begin
         if (frame_start) begin
            cfg <= cfg_in;
         end
         n <= (n == len - 10'h001) ? 10'h000 : n + 10'h001;
         if (kq == qtr[7:0] - 8'h01) begin
            kq <= 8'h00;
            m <= m + 2'h1;
         end else begin
            kq <= kq + 8'h01;
         end
      end
   end

   // stage one: filtered and raw sample of the current cycle
   logic v1, end1;
   logic [1:0] m1;
   logic signed [15:0] raw1;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         v1 <= 1'b0;
         end1 <= 1'b0;
         m1 <= 2'h0;
         raw1 <= 16'sh0000;
      end else begin
         v1 <= smp_take;
         end1 <= smp_take && kq == qtr[7:0] - 8'h01;
         m1 <= m;
         raw1 <= smp_in.hp;
      end
   end

   // stage two: sub-frame energy sums
   logic [35:0] y2;
   logic [31:0] r2;
   logic [47:0] acc, racc, e_cap, td_sum, lt, next_lt;
   logic [47:0] hp_e [0:4];
   logic sub_done;
   logic [1:0] m2;
   assign y2 = 36'(y * y);
   assign r2 = 32'(raw1 * raw1);

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc <= 48'h0;
         racc <= 48'h0;
         e_cap <= 48'h0;
         td_sum <= 48'h0;
         sub_done <= 1'b0;
         m2 <= 2'h0;
      end else begin
         sub_done <= v1 & end1;
         m2 <= m1;
         if (frame_start) begin
            td_sum <= 48'h0;
         end else if (v1 && end1) begin
            td_sum <= 48'(td_sum + acc + y2);
         end
         if (v1) begin
            acc <= end1 ? 48'h0 : 48'(acc + y2);
            racc <= end1 ? 48'h0 : 48'(racc + r2);
            if (end1) begin
               e_cap <= 48'(acc + y2);
            end
         end
      end
   end

   // unfiltered energies, index zero holds the last one of the previous frame
   for (genvar i = 0; i < 5; i++) begin : g_hpe
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
         if (!rstn_in) begin
            hp_e[i] <= 48'h0;
         end else if (i == 0) begin
            if (state == tdst_pkg::ST_DECIDE) begin
               hp_e[i] <= hp_e[4];
            end
         end else if (v1 && end1 && m1 == 2'(i - 1)) begin
            hp_e[i] <= 48'(racc + r2);
         end
      end
   end

   // stage three: long-term energy and threshold test
   logic [6:0] rho;
   logic hit;
   logic [1:0] hit_idx;
   assign next_lt = lt - {2'h0, lt[47:2]} + {2'h0, e_cap[47:2]};
   always_comb begin
      if (cfg.gen_mode) begin
         rho = cfg.inactive ? `TDST_RHO_INACT : `TDST_RHO_ACT;
      end else if (cfg.bw == tdst_pkg::BW_SWB && cfg.low_rate) begin
         rho = `TDST_RHO_SWB;
      end else begin
         rho = `TDST_RHO_OTHER;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lt <= 48'h0;
         hit <= 1'b0;
         hit_idx <= 2'h0;
      end else begin
         if (sub_done) begin
            lt <= next_lt;
         end else if (state == tdst_pkg::ST_DECIDE && (cfg.core_change || cfg.layer_change)) begin
            lt <= {2'h0, td_sum[47:2]};
         end
         if (frame_start) begin
            hit <= 1'b0;
         end else if (sub_done && !hit
            && 56'({e_cap, 1'b0}) >= 56'(rho) * 56'(next_lt)) begin
            hit <= 1'b1;
            hit_idx <= m2;
         end
      end
   end

   // frame decision with narrowband refinement
   logic [50:0] sum_lo, sum_hi, e_in;
   logic [2:0] n_lo, n_hi;
   logic det, drop, flag, hang;
   always_comb begin
      sum_lo = 51'h0;
      sum_hi = 51'h0;
      e_in = 51'h0;
      for (int i = 0; i < 5; i++) begin
         if (3'(i) <= {1'b0, hit_idx}) begin
            sum_lo = sum_lo + 51'(hp_e[i]);
         end else begin
            sum_hi = sum_hi + 51'(hp_e[i]);
         end
         if (i > 0) begin
            e_in = e_in + 51'(hp_e[i]);
         end
      end
      n_lo = {1'b0, hit_idx} + 3'h1;
      n_hi = 3'h4 - {1'b0, hit_idx};
      det = hit & ~cfg.first_generic;
      drop = (cfg.bw == tdst_pkg::BW_NB) && det
         && (64'(sum_hi) * 64'(n_lo) * 64'h10 < 64'(hl_thr_in) * 64'(sum_lo) * 64'(n_hi))
         && (64'(e_in) * 64'h10 > 64'(io_thr_in) * 64'(td_sum));
      flag = (det & ~drop) | hang;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hang <= 1'b0;
         transient_flag_out <= 1'b0;
         flag_valid_out <= 1'b0;
      end else begin
         flag_valid_out <= state == tdst_pkg::ST_DECIDE;
         if (clr) begin
            hang <= 1'b0;
         end else if (state == tdst_pkg::ST_DECIDE) begin
            hang <= det & ~drop;
            transient_flag_out <= flag;
         end
      end
   end

   // segment and emit read path
   logic iss, last_iss, pend, pend_zero, pend_unity, pend_last, pend_kind, buf_ready;
   logic seg_zero, seg_unity;
   logic [1:0] seg;
   logic [9:0] pos, rd_addr, emit_n;
   logic signed [11:0] j;
   logic [23:0] rdata;
   logic signed [32:0] wprod;
   assign emit_n = cfg.pair ? half : len;
   assign j = $signed(12'(seg * qtr) + {2'h0, pos} - {2'h0, eighth});
   assign seg_zero = j[11] || j >= $signed({2'h0, len});
   assign seg_unity = (seg == 2'h0 && pos >= qtr) ? 1'b0 : (seg == 2'h0) ? 1'b1 :
      (seg == 2'h3 && pos >= qtr);
   assign rd_addr = (state == tdst_pkg::ST_SEGMENT) ? 10'(len - 10'h001 - j[9:0]) : pos;
   assign iss = (state == tdst_pkg::ST_SEGMENT || state == tdst_pkg::ST_EMIT)
      && buf_ready && !pend;
   assign last_iss = (state == tdst_pkg::ST_SEGMENT) ? (seg == 2'h3 && pos == half - 10'h001)
      : (pos == emit_n - 10'h001);
   assign wprod = 33'($signed(rdata[15:0]) * $signed({1'b0, win_coef_in}));

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         seg <= 2'h0;
         pos <= 10'h000;
         win_addr_out <= 10'h000;
         pend <= 1'b0;
         pend_zero <= 1'b0;
         pend_unity <= 1'b0;
         pend_last <= 1'b0;
         pend_kind <= 1'b0;
      end else begin
         pend <= iss;
         if (iss) begin
            win_addr_out <= pos;
            pend_zero <= seg_zero & (state == tdst_pkg::ST_SEGMENT);
            pend_unity <= seg_unity | (state == tdst_pkg::ST_EMIT);
            pend_last <= last_iss;
            pend_kind <= state == tdst_pkg::ST_EMIT;
            if (last_iss) begin
               seg <= 2'h0;
               pos <= 10'h000;
            end else if (state == tdst_pkg::ST_SEGMENT && pos == half - 10'h001) begin
               seg <= seg + 2'h1;
               pos <= 10'h000;
            end else begin
               pos <= pos + 10'h001;
            end
         end
      end
   end

   always_comb begin
      push_data.kind = pend_kind;
      push_data.last = pend_last;
      if (pend_zero) begin
         push_data.data = 24'h000000;
      end else if (pend_unity) begin
         push_data.data = rdata;
      end else begin
         push_data.data = {{6{wprod[32]}}, wprod[32:15]};
      end
   end

   // short spectra collection with interleaved placement
   logic [9:0] kc, bstart, bwid, waddr_c;
   logic [3:0] bidx;
   logic [1:0] tc;
   logic coef_take, coef_last, enter_coef;
   assign coef_take = coef_valid_in & coef_ready_out;
   assign coef_last = tc == (cfg.pair ? 2'h1 : 2'h3) && kc == qtr - 10'h001;
   assign enter_coef = (state == tdst_pkg::ST_COEF && flag_valid_out && cfg.pair)
      || (state == tdst_pkg::ST_SEGMENT && iss && last_iss);
   assign waddr_c = cfg.pair ? {kc[8:0], tc[0]}
      : 10'({bstart, 2'h0} + 10'(tc * bwid) + (kc - bstart));

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         coef_ready_out <= 1'b0;
         kc <= 10'h000;
         tc <= 2'h0;
         bidx <= 4'h0;
         bstart <= 10'h000;
         bwid <= 10'h000;
      end else if (enter_coef) begin
         coef_ready_out <= 1'b1;
         bwid <= band_len(cfg.bw, 4'h0, 10'h000, qtr);
      end else if (coef_take) begin
         if (kc == qtr - 10'h001) begin
            kc <= 10'h000;
            tc <= coef_last ? 2'h0 : tc + 2'h1;
            bidx <= 4'h0;
            bstart <= 10'h000;
            bwid <= band_len(cfg.bw, 4'h0, 10'h000, qtr);
            coef_ready_out <= !coef_last;
         end else begin
            kc <= kc + 10'h001;
            if (kc == bstart + bwid - 10'h001) begin
               bidx <= bidx + 4'h1;
               bstart <= bstart + bwid;
               bwid <= band_len(cfg.bw, bidx + 4'h1, bstart + bwid, qtr);
            end
         end
      end
   end

   // sequencing
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= tdst_pkg::ST_COLLECT;
         drain <= 2'h0;
         smp_ready_out <= 1'b1;
      end else begin
         case (state)
            tdst_pkg::ST_COLLECT: begin
               if (smp_take && n == len - 10'h001) begin
                  state <= tdst_pkg::ST_DRAIN;
                  drain <= `TDST_DRAIN_CYC;
                  smp_ready_out <= 1'b0;
               end
            end
            tdst_pkg::ST_DRAIN: begin
               if (drain == 2'h0) begin
                  state <= tdst_pkg::ST_DECIDE;
               end else begin
                  drain <= drain - 2'h1;
               end
            end
            tdst_pkg::ST_DECIDE: begin
               if (!flag) begin
                  state <= tdst_pkg::ST_COLLECT;
                  smp_ready_out <= 1'b1;
               end else if (cfg.pair) begin
                  state <= tdst_pkg::ST_COEF;
               end else begin
                  state <= tdst_pkg::ST_SEGMENT;
               end
            end
            tdst_pkg::ST_SEGMENT: begin
               if (iss && last_iss) begin
                  state <= tdst_pkg::ST_COEF;
               end
            end
            tdst_pkg::ST_COEF: begin
               if (coef_take && coef_last) begin
                  state <= tdst_pkg::ST_EMIT;
               end
            end
            tdst_pkg::ST_EMIT: begin
               if (iss && last_iss) begin
                  state <= tdst_pkg::ST_COLLECT;
                  smp_ready_out <= 1'b1;
               end
            end
            default: begin
               state <= tdst_pkg::ST_COLLECT;
               smp_ready_out <= 1'b1;
            end
         endcase
      end
   end

   tdst_mem u_mem (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .we_in(smp_take | coef_take),
      .waddr_in(smp_take ? n : waddr_c),
      .wdata_in(smp_take ? {{8{smp_in.aliased[15]}}, smp_in.aliased} : coef_in),
      .raddr_in(rd_addr),
      .rdata_out(rdata)
   );

   tdst_skid #(.W(26)) u_buf (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .in_valid_in(pend),
      .in_data_in(push_data),
      .in_ready_out(buf_ready),
      .out_valid_out(out_valid_out),
      .out_data_out(out_data_out),
      .out_ready_in(out_ready_in)
   );
endmodule
`default_nettype wire

// [tdst_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tdst_regs.svh"
module tdst_core_assertions (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // sample side
   input wire logic smp_valid_in,
   input wire logic smp_ready_out,
   input wire tdst_pkg::tdst_cfg_t cfg_in,
   // output side
   input wire logic coef_ready_out,
   input wire logic out_valid_out,
   input wire logic out_ready_in,
   input wire tdst_pkg::tdst_out_t out_data_out,
   input wire logic transient_flag_out,
   input wire logic flag_valid_out
);
   logic [9:0] n_take;
   logic [9:0] len;
   logic last_take;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   always_comb begin
      case (cfg_in.bw)
         tdst_pkg::BW_NB: len = `TDST_LEN_NB;
         tdst_pkg::BW_WB: len = `TDST_LEN_WB;
         tdst_pkg::BW_SWB: len = `TDST_LEN_SWB;
         default: len = `TDST_LEN_FB;
      endcase
   end
   assign last_take = smp_valid_in && smp_ready_out && (n_take == len - 10'h001);
   // counts taken samples within a frame
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         n_take <= 10'h000;
      end else if (last_take) begin
         n_take <= 10'h000;
      end else if (smp_valid_in && smp_ready_out) begin
         n_take <= n_take + 10'h001;
      end
   end
   a_flag_after_last: assert property (last_take |-> ##5 flag_valid_out)
      else $error("flag not given five cycles after last sample");
   a_ready_drops: assert property (last_take |=> !smp_ready_out)
      else $error("sample ready stayed high after frame end");
   a_flag_pulse: assert property (flag_valid_out |=> !flag_valid_out)
      else $error("flag valid longer than one cycle");
   a_flag_holds: assert property (!flag_valid_out |-> $stable(transient_flag_out))
      else $error("flag changed without a decision");
   a_quiet_frame: assert property (flag_valid_out && !transient_flag_out |=> smp_ready_out)
      else $error("frame without transient did not return to collection");
   a_seg_start: assert property (flag_valid_out && transient_flag_out && !cfg_in.pair
      |-> ##[1:12] out_valid_out && !out_data_out.kind)
      else $error("no segment word after transient decision");
   a_out_holds: assert property (out_valid_out && !out_ready_in
      |=> out_valid_out && $stable(out_data_out))
      else $error("output word lost under stall");
   a_coef_excl: assert property (coef_ready_out |-> !smp_ready_out && !flag_valid_out)
      else $error("coefficient intake overlaps sample collection");
endmodule
bind tdst_core tdst_core_assertions chk (.clk_sys_in, .rstn_in, .smp_valid_in, .smp_ready_out,
   .cfg_in, .coef_ready_out, .out_valid_out, .out_ready_in, .out_data_out,
   .transient_flag_out, .flag_valid_out);
`default_nettype wire

// [tdst_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define TDST_CHK(what, got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("FAIL %s expected %0h seen %0h", what, exp, got); end end
module tdst_core_tb;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic smp_valid_in = 1'b0;
   tdst_pkg::tdst_in_t smp_in = '0;
   tdst_pkg::tdst_cfg_t cfg_in = 9'h080;
   logic [7:0] hl_thr_in = 8'h10;
   logic [7:0] io_thr_in = 8'h10;
   logic smp_ready_out, coef_valid_in, coef_ready_out, out_valid_out, out_ready_in;
   logic transient_flag_out, flag_valid_out;
   logic [9:0] win_addr_out;
   logic [15:0] win_coef_in;
   logic [23:0] coef_in;
   tdst_pkg::tdst_out_t out_data_out;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int seg_i = 0;
   int coef_i = 0;
   int j, e, p;
   tdst_core dut (.clk_sys_in, .rstn_in, .smp_valid_in, .smp_in, .smp_ready_out, .cfg_in,
      .hl_thr_in, .io_thr_in, .win_addr_out, .win_coef_in, .coef_valid_in, .coef_in,
      .coef_ready_out, .out_valid_out, .out_ready_in, .out_data_out, .transient_flag_out,
      .flag_valid_out);
   tdst_partner far (.clk_sys_in, .rstn_in, .coef_ready_in(coef_ready_out),
      .win_addr_in(win_addr_out), .coef_valid_out(coef_valid_in), .coef_out(coef_in),
      .win_coef_out(win_coef_in), .sink_ready_out(out_ready_in));
   always #12.5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // output monitor, wideband frame of 320 samples
   always @(posedge clk_sys_in) begin
      if (flag_valid_out) begin
         seg_i = 0;
         coef_i = 0;
      end else if (out_valid_out && out_ready_in && !out_data_out.kind) begin
         j = (seg_i / 160) * 80 + seg_i % 160 - 40;
         p = seg_i % 160;
         e = (j < 0 || j >= 320) ? 0 : 419 - j;
         if (!((seg_i < 160 && p < 80) || (seg_i >= 480 && p >= 80))) begin
            e = e * (32767 - p) / 32768;
         end
         `TDST_CHK("segment word", out_data_out.data, 24'(e))
         `TDST_CHK("segment last", out_data_out.last, 1'(seg_i == 639))
         seg_i++;
      end else if (out_valid_out && out_ready_in) begin
         e = cfg_in.pair ? coef_i % 2 * 80 + coef_i / 2
            : (coef_i % 64 / 16) * 80 + coef_i / 64 * 16 + coef_i % 16;
         p = cfg_in.pair ? 159 : 319;
         `TDST_CHK("coefficient", out_data_out.data, 24'(e))
         `TDST_CHK("coefficient last", out_data_out.last, 1'(coef_i == p))
         coef_i++;
      end
   end
   task automatic run_frame(input string name, input logic [15:0] amp, input logic exp_flag);
      int n;
      int k;
      n = 0;
      while (n < 320) begin
         smp_valid_in <= 1'b1;
         smp_in.hp <= n[0] ? amp : -amp;
         smp_in.aliased <= 16'(n + 100);
         @(posedge clk_sys_in);
         if (smp_ready_out) n++;
      end
      smp_valid_in <= 1'b0;
      k = 0;
      while (!flag_valid_out && k < 20) begin
         @(posedge clk_sys_in);
         k++;
      end
      `TDST_CHK("flag in time", k < 20, 1'b1)
      `TDST_CHK(name, transient_flag_out, exp_flag)
      k = 0;
      while (!smp_ready_out && k < 6000) begin
         @(posedge clk_sys_in);
         k++;
      end
      `TDST_CHK("frame done", k < 6000, 1'b1)
      repeat (10) @(posedge clk_sys_in);
      `TDST_CHK("segment count", seg_i, exp_flag && !cfg_in.pair ? 640 : 0)
      `TDST_CHK("coefficient count", coef_i, exp_flag ? (cfg_in.pair ? 160 : 320) : 0)
      $display("test %s done", name);
   endtask
   task automatic test_silence();
      run_frame("silence", 16'h0000, 1'b1);
   endtask
   task automatic test_hangover();
      run_frame("hangover", 16'h03E8, 1'b1);
   endtask
   task automatic test_steady();
      run_frame("steady", 16'h03E8, 1'b0);
   endtask
   task automatic test_pair();
      rstn_in <= 1'b0;
      cfg_in <= 9'h081;
      repeat (16) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      run_frame("pair", 16'h0000, 1'b1);
   endtask
   task automatic test_first_generic();
      rstn_in <= 1'b0;
      cfg_in <= 9'h0C2;
      repeat (16) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      run_frame("first generic", 16'h0000, 1'b0);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      test_silence();
      test_hangover();
      test_steady();
      test_pair();
      test_first_generic();
      give_verdict();
   end
endmodule
`default_nettype wire

// [tdst_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module tdst_mem #(
   parameter int W = 24,
   parameter int D = 960,
   parameter int AW = 10
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // write port
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [W-1:0] wdata_in,
   // read port, data one cycle later
   input wire logic [AW-1:0] raddr_in,
   output logic [W-1:0] rdata_out
);
   logic [W-1:0] mem [0:D-1];

   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule
`default_nettype wire

// [tdst_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module tdst_partner (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // coefficient source
   input wire logic coef_ready_in,
   output logic coef_valid_out,
   output logic [23:0] coef_out,
   // window table and output sink
   input wire logic [9:0] win_addr_in,
   output logic [15:0] win_coef_out,
   output logic sink_ready_out
);
   logic [7:0] cyc;
   // falling ramp, each window index gives its own weight
   assign win_coef_out = 16'h7FFF - {6'h00, win_addr_in};
   assign coef_valid_out = 1'b1;
   // sink stalls four cycles in sixteen
   assign sink_ready_out = (cyc[3:2] != 2'h0);
   // coefficient value is its arrival index since intake opened
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cyc <= 8'h00;
         coef_out <= 24'h000000;
      end else begin
         cyc <= cyc + 8'h01;
         if (coef_ready_in) begin
            coef_out <= coef_out + 24'h000001;
         end else begin
            coef_out <= 24'h000000;
         end
      end
   end
endmodule
`default_nettype wire

// [tdst_pkg.sv]
package tdst_pkg;
   typedef enum logic [2:0] {
      ST_COLLECT = 3'h0,
      ST_DRAIN = 3'h1,
      ST_DECIDE = 3'h3,
      ST_SEGMENT = 3'h2,
      ST_COEF = 3'h6,
      ST_EMIT = 3'h7
   } tdst_state_t;
   typedef enum logic [1:0] {BW_NB = 2'h0, BW_WB = 2'h1, BW_SWB = 2'h2, BW_FB = 2'h3} tdst_bw_t;
   typedef struct packed {
      logic signed [15:0] hp;
      logic signed [15:0] aliased;
   } tdst_in_t;
   typedef struct packed {
      tdst_bw_t bw;
      logic gen_mode;
      logic inactive;
      logic low_rate;
      logic core_change;
      logic layer_change;
      logic first_generic;
      logic pair;
   } tdst_cfg_t;
   typedef struct packed {
      logic kind;
      logic last;
      logic [23:0] data;
   } tdst_out_t;
endpackage

// [tdst_regs.svh]
`ifndef TDST_REGS_SVH
`define TDST_REGS_SVH
`define TDST_HP_POLE 16'h3F1E
`define TDST_HP_ZERO 16'h5F91
`define TDST_RHO_INACT 7'h14
`define TDST_RHO_ACT 7'h51
`define TDST_RHO_SWB 7'h1B
`define TDST_RHO_OTHER 7'h0C
`define TDST_LEN_NB 10'h0A0
`define TDST_LEN_WB 10'h140
`define TDST_LEN_SWB 10'h280
`define TDST_LEN_FB 10'h3C0
`define TDST_BAND_A 8'h10
`define TDST_BAND_B 8'h18
`define TDST_BAND_C 8'h20
`define TDST_WIN_UNITY 16'h7FFF
`define TDST_MEM_DEPTH 960
`define TDST_DRAIN_CYC 2'h2
`endif

// [tdst_skid.sv]
`timescale 1ns/1ps
`default_nettype none
module tdst_skid #(
   parameter int W = 26
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // filling side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // draining side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   logic [W-1:0] spare;
   logic push;
   logic head_free;

   assign push = in_valid_in & in_ready_out;
   assign head_free = !out_valid_out || out_ready_in;

   // head register feeds the port, spare catches a word during a stall
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         out_valid_out <= 1'b0;
         out_data_out <= '0;
         spare <= '0;
         in_ready_out <= 1'b1;
      end else if (head_free) begin
         if (!in_ready_out) begin
            out_data_out <= spare;
            out_valid_out <= 1'b1;
            in_ready_out <= 1'b1;
         end else begin
            out_valid_out <= push;
            if (push) begin
               out_data_out <= in_data_in;
            end
         end
      end else if (push) begin
         spare <= in_data_in;
         in_ready_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire
